/* logic/vpsrd_pkg.sv */
// shared constants of the line-data readout block
package vpsrd_pkg;
    // ************************************************************
    // bus addressing
    // ************************************************************
    localparam logic [5:0] ADDR_BASE   = 6'h08;
    localparam int         BYTE_W      = 8;
    // ************************************************************
    // read sequence layout
    // ************************************************************
    localparam int         STORE_BYTES = 6;
    localparam logic [2:0] PTR_LAST    = 3'h6;
    localparam logic [7:0] FILL_BYTE   = 8'hFF;
    localparam logic [3:0] SRC_SLOT0   = 4'hB;
    localparam logic [3:0] SRC_SLOT1   = 4'hC;
    localparam logic [3:0] SRC_SLOT2   = 4'hD;
    localparam logic [3:0] SRC_SLOT3   = 4'hE;
    localparam logic [3:0] SRC_SLOT4   = 4'h5;
    localparam logic [3:0] SRC_SLOT5   = 4'hF;
    localparam logic [2:0] SLOT_NONE   = 3'h7;
    localparam logic [3:0] SRC_FIRST   = 4'h1;
    // ************************************************************
    // reset values and buffering
    // ************************************************************
    localparam logic       DV_RESET    = 1'b1;
    localparam logic       FF_RESET    = 1'b0;
    localparam int         FIFO_DEPTH  = 32;
    localparam int         SYNC_W      = 4;
    // bus pins reset to their idle high level, no false edge after reset
    localparam logic [3:0] SYNC_INIT   = 4'h3;
endpackage

/* logic/vpsrd_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module vpsrd_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         resetn_in,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // vpsrd_sync

/* logic/vpsrd_fifo.sv */
// flip-flop fifo between acquisition and readout store
`timescale 1ns/10ps
module vpsrd_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         resetn_in,
    // fill side
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    // drain side
    output logic      [W-1:0] out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    wire           push = in_valid_in && in_ready_out;
    wire           pop  = out_valid_out && out_ready_in;
    wire [AW:0]    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    assign out_data_out = mem_q[rd_q];

    always_ff @(posedge mclk_in) begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end

    // full and empty kept as flops so the ports come from registers
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_q          <= '0;
            rd_q          <= '0;
            cnt_q         <= '0;
            in_ready_out  <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            wr_q          <= wr_q + AW'(push);
            rd_q          <= rd_q + AW'(pop);
            cnt_q         <= cnt_d;
            in_ready_out  <= cnt_d != (AW+1)'(DEPTH);
            out_valid_out <= cnt_d != '0;
        end
    end
endmodule // vpsrd_fifo

/* logic/vpsrd_top.sv */
// line-data readout, bus slave and field flag outputs
//
// Contract
// - read bytes are source bytes 11,12,13,14,5,15 then a seventh
// - each of the first six read bytes carries its source byte in reversed bit order
// - seventh read byte is all ones
// - valid flag goes low in line 16 once valid data arrived
// - valid flag returns high at start of each line 16; a line stored in the same cycle keeps it low
// - valid flag high at reset and on master no-acknowledge
// - field flag rises at first field, falls at second field
// - test input high: both flags copy address-select level
// - start resets byte pointer; master acknowledge advances it
// - no loading of new line data while bus access runs
// - store only error-free lines; signal with valid falling edge
// - answer 20/21 hex with select low, 22/23 hex with it high
`timescale 1ns/10ps
module vpsrd_top #(
    parameter int FIFO_DEPTH = vpsrd_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    // serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // strap and test pins
    input  wire logic       address_select_pin_in,
    input  wire logic       test_mode_input_in,
    // video timing events
    input  wire logic       line16_start_in,
    input  wire logic       first_field_start_in,
    input  wire logic       second_field_start_in,
    // acquired byte stream
    input  wire logic [7:0] acq_data_in,
    input  wire logic       acq_err_in,
    input  wire logic       acq_last_in,
    input  wire logic       acq_valid_in,
    output logic            acq_ready_out,
    // status flags
    output logic            data_valid_n_out,
    output logic            first_field_flag_out
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            rev8[i] = b[7-i];
    endfunction

    function automatic logic [2:0] slot_of(input logic [3:0] idx);
        case (idx)
            vpsrd_pkg::SRC_SLOT0: slot_of = 3'h0;
            vpsrd_pkg::SRC_SLOT1: slot_of = 3'h1;
            vpsrd_pkg::SRC_SLOT2: slot_of = 3'h2;
            vpsrd_pkg::SRC_SLOT3: slot_of = 3'h3;
            vpsrd_pkg::SRC_SLOT4: slot_of = 3'h4;
            vpsrd_pkg::SRC_SLOT5: slot_of = 3'h5;
            default:              slot_of = vpsrd_pkg::SLOT_NONE;
        endcase
    endfunction

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACKA = 6'h04,
        ST_TX   = 6'h08,
        ST_ACKM = 6'h10,
        ST_RX   = 6'h20
    } vpsrd_state_e;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] pins_s;
    logic       scl_d_q;
    logic       sda_d_q;
    vpsrd_sync #(.W(vpsrd_pkg::SYNC_W), .INIT(vpsrd_pkg::SYNC_INIT)) u_sync (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .async_in  ({test_mode_input_in, address_select_pin_in,
                     sda_in, scl_in}),
        .sync_out  (pins_s)
    );
    wire scl_s  = pins_s[0];
    wire sda_s  = pins_s[1];
    wire cs_s   = pins_s[2];
    wire test_s = pins_s[3];

    wire scl_rise = scl_s && !scl_d_q;
    wire scl_fall = !scl_s && scl_d_q;
    wire start_ev = scl_s && scl_d_q && !sda_s && sda_d_q;
    wire stop_ev  = scl_s && scl_d_q && sda_s && !sda_d_q;

    // ************************************************************
    // acquisition fifo and line store
    // ************************************************************
    logic [9:0] fifo_data;
    logic       fifo_valid;
    logic       bus_busy_q;
    logic [3:0] src_idx_q;
    logic       err_q;
    logic [7:0] shadow_q [vpsrd_pkg::STORE_BYTES];
    logic [7:0] out_q    [vpsrd_pkg::STORE_BYTES];

    vpsrd_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_in       (mclk_in),
        .resetn_in     (resetn_in),
        .in_data_in    ({acq_last_in, acq_err_in, acq_data_in}),
        .in_valid_in   (acq_valid_in),
        .in_ready_out  (acq_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (!bus_busy_q)
    );

    // draining stalls during an access, so the fifo absorbs the line
    wire       pop      = fifo_valid && !bus_busy_q;
    wire [7:0] pop_byte = fifo_data[7:0];
    wire       pop_err  = fifo_data[8];
    wire       pop_last = fifo_data[9];
    wire [2:0] pop_slot = slot_of(src_idx_q);
    wire       err_any  = err_q || pop_err;
    wire       commit   = pop && pop_last && !err_any;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_idx_q <= vpsrd_pkg::SRC_FIRST;
            err_q     <= 1'b0;
        end else if (pop) begin
            src_idx_q <= pop_last ? vpsrd_pkg::SRC_FIRST : src_idx_q + 4'h1;
            err_q     <= pop_last ? 1'b0 : err_any;
        end
    end

    for (genvar g = 0; g < vpsrd_pkg::STORE_BYTES; g++) begin : g_store
        wire hit = pop && pop_slot == 3'(g);
        always_ff @(posedge mclk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                shadow_q[g] <= 8'h00;
                out_q[g]    <= 8'h00;
            end else begin
                if (hit)
                    shadow_q[g] <= pop_byte;
                if (commit)
                    out_q[g] <= hit ? pop_byte : shadow_q[g];
            end
        end
    end

    // ************************************************************
    // bus slave
    // ************************************************************
    vpsrd_state_e state_q;
    logic [7:0]   shift_q;
    logic [7:0]   tx_q;
    logic [3:0]   bit_q;
    logic [2:0]   ptr_q;
    logic         rw_q;

    wire       addr_hit = shift_q[7:1] == {vpsrd_pkg::ADDR_BASE, cs_s};
    wire [7:0] sel_raw  = out_q[ptr_q];
    wire [7:0] sel_byte = (ptr_q >= vpsrd_pkg::PTR_LAST) ?
                          vpsrd_pkg::FILL_BYTE : rev8(sel_raw);
    wire       load_tx  = state_q == ST_ACKA && scl_fall && rw_q;
    wire       m_ack    = state_q == ST_ACKM && scl_rise && !sda_s;
    wire       m_nak    = state_q == ST_ACKM && scl_rise && sda_s;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            tx_q       <= 8'h00;
            bit_q      <= 4'h0;
            ptr_q      <= 3'h0;
            rw_q       <= 1'b0;
            bus_busy_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (start_ev) begin
            state_q    <= ST_ADDR;
            bit_q      <= 4'h0;
            ptr_q      <= 3'h0;
            sda_oe_out <= 1'b0;
        end else if (stop_ev) begin
            state_q    <= ST_IDLE;
            bus_busy_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q   <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        if (addr_hit) begin
                            state_q    <= ST_ACKA;
                            rw_q       <= shift_q[0];
                            sda_oe_out <= 1'b1;
                            bus_busy_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ACKA: begin
                    if (scl_fall) begin
                        bit_q <= rw_q ? 4'h1 : 4'h0;
                        if (rw_q) begin
                            state_q    <= ST_TX;
                            tx_q       <= sel_byte;
                            sda_oe_out <= !sel_byte[7];
                        end else begin
                            state_q    <= ST_RX;
                            sda_oe_out <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h8) begin
                            state_q    <= ST_ACKM;
                            sda_oe_out <= 1'b0;
                        end else begin
                            tx_q       <= {tx_q[6:0], 1'b1};
                            sda_oe_out <= !tx_q[6];
                            bit_q      <= bit_q + 4'h1;
                        end
                    end
                end
                ST_ACKM: begin
                    if (m_ack) begin
                        state_q <= ST_ACKA;
                        if (ptr_q != vpsrd_pkg::PTR_LAST)
                            ptr_q <= ptr_q + 3'h1;
                    end else if (m_nak) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RX: begin
                    // written byte is acknowledged and dropped
                    if (scl_rise) begin
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        state_q    <= ST_ACKA;
                        sda_oe_out <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    logic dv_n_q;
    logic field_q;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dv_n_q               <= vpsrd_pkg::DV_RESET;
            field_q              <= vpsrd_pkg::FF_RESET;
            data_valid_n_out     <= vpsrd_pkg::DV_RESET;
            first_field_flag_out <= vpsrd_pkg::FF_RESET;
            sda_out              <= 1'b0;
        end else begin
            if (commit)
                dv_n_q <= 1'b0;
            else if (line16_start_in || m_nak)
                dv_n_q <= 1'b1;
            if (first_field_start_in)
                field_q <= 1'b1;
            else if (second_field_start_in)
                field_q <= 1'b0;
            data_valid_n_out     <= test_s ? cs_s : dv_n_q;
            first_field_flag_out <= test_s ? cs_s : field_q;
            sda_out              <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    chk_order_fifth: assert property (load_tx && ptr_q == 3'h4
        |=> tx_q == rev8($past(out_q[4]))) else $error("byte 5 wrong");
    chk_bit_reverse: assert property (load_tx && ptr_q < 3'h6
        |=> tx_q[7] == $past(sel_raw[0]) && tx_q[0] == $past(sel_raw[7]))
        else $error("bit order not reversed");
    chk_fill_byte: assert property (load_tx && ptr_q == 3'h6
        |=> tx_q == 8'hFF) else $error("seventh byte not ones");
    chk_valid_low: assert property (commit
        |=> !dv_n_q ##1 ($past(test_s) || !data_valid_n_out))
        else $error("valid flag not low after store");
    chk_valid_high: assert property (line16_start_in && !commit
        |=> dv_n_q) else $error("valid flag not raised at line 16");
    chk_nak_high: assert property (m_nak
        |=> dv_n_q) else $error("valid flag not raised on no-ack");
    chk_field_flag: assert property (second_field_start_in
        && !first_field_start_in |=> !field_q)
        else $error("field flag not cleared");
    chk_test_copy: assert property (test_s && $stable(cs_s)
        |=> data_valid_n_out == $past(cs_s)
        && first_field_flag_out == $past(cs_s))
        else $error("test mode does not copy select");
    chk_ptr_start: assert property (start_ev
        |=> ptr_q == 3'h0) else $error("pointer not reset");
    chk_ptr_step: assert property (m_ack && ptr_q < 3'h6
        |=> ptr_q == $past(ptr_q) + 3'h1) else $error("pointer not advanced");
    chk_no_load_busy: assert property ($past(bus_busy_q)
        && bus_busy_q |-> !pop && $stable(out_q[0]))
        else $error("store during access");
    chk_err_drop: assert property (pop && pop_last && err_any
        |=> $stable(out_q[5])) else $error("errored line stored");
    chk_addr_ack: assert property (state_q == ST_ADDR && scl_fall
        && bit_q == 4'h8 && !addr_hit |=> !sda_oe_out)
        else $error("foreign address acknowledged");

    cov_commit: cover property (commit);
    cov_read7:  cover property (load_tx && ptr_q == 3'h6);
    cov_nak:    cover property (m_nak);
    cov_stall:  cover property (bus_busy_q && fifo_valid);
endmodule // vpsrd_top

/* testbench/vpsrd_i2c_master.sv */
// bus master model reading the readout block over the two-wire bus
`timescale 1ns/10ps
module vpsrd_i2c_master #(
    parameter int QTR = 10
) (
    // clock
    input  wire logic mclk_in,
    // bus lines
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // ************************************************************
    // bit and byte tasks, lines change only just after mclk edges
    // ************************************************************
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic q();
        repeat (QTR) @(posedge mclk_in);
    endtask

    task automatic start();
        sda_low_out <= 1'b0;
        q();
        scl_out <= 1'b1;
        q();
        sda_low_out <= 1'b1;
        q();
        scl_out <= 1'b0;
        q();
    endtask

    // data only moves while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_low_out <= ~b;
        q();
        scl_out <= 1'b1;
        q();
        r = sda_in;
        q();
        scl_out <= 1'b0;
        q();
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, r);
    endtask

    // stop, then idle bus so line updates are not held off
    task automatic stop();
        sda_low_out <= 1'b1;
        q();
        scl_out <= 1'b1;
        q();
        sda_low_out <= 1'b0;
        q();
        q();
    endtask
endmodule // vpsrd_i2c_master

/* testbench/vps_readout_and_field_flags_test.sv */
// self-checking bench for the line-data readout block
`timescale 1ns/10ps
module vps_readout_and_field_flags_test;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic        mclk_in, resetn_in, sel, tmode, l16, f1, f2;
    logic        acq_err, acq_last, acq_valid, ack_s;
    logic [7:0]  acq_data, d_s;
    wire logic   scl, m_low, sda_o, sda_oe, acq_ready, dv_n, ff;
    // open-drain line with pull-up
    wire logic   sda = !(m_low || (sda_oe && !sda_o));
    int          errors, checks_done, cycles;
    logic [31:0] seed;
    logic [7:0]  exp_b [0:5];
    logic [7:0]  old_b [0:5];
    logic [3:0]  src_map [0:5] = '{4'hB, 4'hC, 4'hD, 4'hE, 4'h5, 4'hF};

    vpsrd_top #(.FIFO_DEPTH(32)) u_vpsrd_top (
        .mclk_in(mclk_in), .resetn_in(resetn_in),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .address_select_pin_in(sel), .test_mode_input_in(tmode),
        .line16_start_in(l16), .first_field_start_in(f1),
        .second_field_start_in(f2), .acq_data_in(acq_data),
        .acq_err_in(acq_err), .acq_last_in(acq_last),
        .acq_valid_in(acq_valid), .acq_ready_out(acq_ready),
        .data_valid_n_out(dv_n), .first_field_flag_out(ff)
    );
    vpsrd_i2c_master u_vpsrd_i2c_master (
        .mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low)
    );

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = b[7 - i];
        return r;
    endfunction

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // one-cycle event pulse: bits are line 16, first field, second field
    task automatic pulse(input logic [2:0] which);
        {l16, f1, f2} <= which;
        tick(1);
        {l16, f1, f2} <= 3'h0;
        tick(3);
    endtask

    // 15 random bytes; a bad line has a biphase error on byte 7
    task automatic push_line(input logic bad);
        logic [7:0] b [1:15];
        for (int i = 1; i <= 15; i++) begin
            b[i] = 8'(next_rand());
            acq_data <= b[i];
            acq_err <= bad && (i == 7);
            acq_last <= (i == 15);
            acq_valid <= 1'b1;
            do tick(1); while (acq_ready !== 1'b1);
        end
        acq_valid <= 1'b0;
        if (!bad) begin
            for (int k = 0; k < 6; k++) exp_b[k] = rev8(b[src_map[k]]);
        end
    endtask

    task automatic wait_dv(input logic lvl, input int lim);
        for (int i = 0; i < lim && dv_n !== lvl; i++) tick(1);
    endtask

    task automatic read_seq(input logic [7:0] addr, input int n,
                            input logic want_ack);
        logic ack;
        logic [7:0] d;
        u_vpsrd_i2c_master.start();
        u_vpsrd_i2c_master.send(addr, ack);
        check("address ack", {7'h0, ack}, {7'h0, want_ack});
        for (int k = 0; k < n && ack; k++) begin
            u_vpsrd_i2c_master.recv(k < n - 1, d);
            check("read byte", d, (k < 6) ? exp_b[k] : 8'hFF);
        end
        u_vpsrd_i2c_master.stop();
    endtask

    // hang guard: all tests need well under this many cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            complete_run();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed = 32'h11E077FB;
        {errors, checks_done, cycles} = '0;
        {resetn_in, sel, tmode, l16, f1, f2} = '0;
        {acq_err, acq_last, acq_valid, acq_data} = '0;
        tick(16);
        resetn_in <= 1'b1;
        tick(4);
        check("valid at reset", {7'h0, dv_n}, 8'h01);
        check("field at reset", {7'h0, ff}, 8'h00);
        pulse(3'h2);
        check("field first", {7'h0, ff}, 8'h01);
        pulse(3'h1);
        check("field second", {7'h0, ff}, 8'h00);
        $display("test reset and field done");
        pulse(3'h4);
        push_line(1'b0);
        wait_dv(1'b0, 100);
        check("valid after line", {7'h0, dv_n}, 8'h00);
        read_seq(8'h21, 8, 1'b1);
        check("valid after refusal", {7'h0, dv_n}, 8'h01);
        $display("test read done");
        pulse(3'h4);
        push_line(1'b1);
        tick(60);
        check("valid bad line", {7'h0, dv_n}, 8'h01);
        read_seq(8'h21, 3, 1'b1);
        push_line(1'b0);
        wait_dv(1'b0, 100);
        pulse(3'h4);
        check("valid at line 16", {7'h0, dv_n}, 8'h01);
        $display("test error line done");
        // new line arrives while the bus is busy; old bytes must stay
        old_b = exp_b;
        u_vpsrd_i2c_master.start();
        u_vpsrd_i2c_master.send(8'h21, ack_s);
        u_vpsrd_i2c_master.recv(1'b1, d_s);
        check("busy byte 1", d_s, old_b[0]);
        push_line(1'b0);
        tick(60);
        u_vpsrd_i2c_master.recv(1'b1, d_s);
        check("busy byte 2", d_s, old_b[1]);
        u_vpsrd_i2c_master.recv(1'b0, d_s);
        u_vpsrd_i2c_master.stop();
        wait_dv(1'b0, 200);
        check("valid after busy", {7'h0, dv_n}, 8'h00);
        read_seq(8'h21, 7, 1'b1);
        $display("test busy done");
        sel <= 1'b1;
        tick(5);
        read_seq(8'h21, 1, 1'b0);
        read_seq(8'h23, 2, 1'b1);
        // write with select high: address and data byte both acknowledged
        u_vpsrd_i2c_master.start();
        u_vpsrd_i2c_master.send(8'h22, ack_s);
        check("write addr ack", {7'h0, ack_s}, 8'h01);
        u_vpsrd_i2c_master.send(8'(next_rand()), ack_s);
        check("write data ack", {7'h0, ack_s}, 8'h01);
        u_vpsrd_i2c_master.stop();
        read_seq(8'h23, 1, 1'b1);
        $display("test address select done");
        tmode <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            sel <= v[0];
            tick(6);
            check("test valid", {7'h0, dv_n}, {7'h0, v[0]});
            check("test field", {7'h0, ff}, {7'h0, v[0]});
        end
        tmode <= 1'b0;
        $display("test mode done");
        complete_run();
    end
endmodule // vps_readout_and_field_flags_test
